// File: rtl/spio_pkg.sv
package spio_pkg;

    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_A_LATCH = 4'h0;
    localparam logic [3:0] IDX_B_LATCH = 4'h1;
    localparam logic [3:0] IDX_C_LATCH = 4'h2;
    localparam logic [3:0] IDX_D_LATCH = 4'h3;
    localparam logic [3:0] IDX_A_DIR = 4'h4;
    localparam logic [3:0] IDX_B_DIR = 4'h5;
    localparam logic [3:0] IDX_C_DIR = 4'h6;
    localparam logic [3:0] IDX_D_DIR = 4'h7;
    localparam logic [3:0] IDX_E_LATCH = 4'h8;
    localparam logic [3:0] IDX_F_LATCH = 4'h9;
    localparam logic [3:0] IDX_GAP_LO = 4'hA;
    localparam logic [3:0] IDX_GAP_HI = 4'hB;
    localparam logic [3:0] IDX_E_DIR = 4'hC;
    localparam logic [3:0] IDX_F_DIR = 4'hD;
    localparam logic [3:0] IDX_LAST = 4'hD;

    // Per port tables, element 0 is port A
    localparam int NUM_PORTS = 6;
    localparam logic [5:0][3:0] LATCH_IDX = {
        IDX_F_LATCH, IDX_E_LATCH, IDX_D_LATCH, IDX_C_LATCH, IDX_B_LATCH, IDX_A_LATCH};
    localparam logic [5:0][3:0] DIR_IDX = {
        IDX_F_DIR, IDX_E_DIR, IDX_D_DIR, IDX_C_DIR, IDX_B_DIR, IDX_A_DIR};
    localparam logic [5:0][7:0] LATCH_MASK = {8'h0F, 8'hFF, 8'h7F, 8'h1F, 8'hFF, 8'hFF};
    localparam logic [5:0][7:0] DIR_MASK = {8'h0F, 8'hFF, 8'h7F, 8'h9F, 8'hFF, 8'hFF};
    localparam logic [5:0][7:0] PIN_MASK = {8'h0F, 8'hFF, 8'h7F, 8'h1F, 8'hFF, 8'hFF};
    localparam logic [7:0] DIR_RESET = 8'h00;

    // Special pins
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int MCLK_EN_BIT = 7;
    localparam int MCLK_PIN = 2;

    // AXI4-Lite answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : spio_pkg

// File: rtl/spio_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Forty pins in six ports, latch and direction
// - Each pin selectable input or output
// - Port A latch at 0x0000, kept by reset
// - Port B latch at 0x0001, kept by reset
// - Port C latch bits 4..0, upper read zero
// - Port D latch bits 6..0, bit 7 zero
// - Port A direction at 0x0004, eight bits
// - Port B direction at 0x0005, resets zero
// - Port C direction: clock enable, bits 4..0
// - Port D direction bits 6..0, reset zero
// - Port E latch at 0x0008, kept by reset
// - Port F latch bits 3..0, kept by reset
// - Port E direction at 0x000C, resets zero
// - Port F direction bits 3..0, reset zero
// - Read returns latch if output, else pin
// - Reset clears port A direction bits
// - ADC pin reads zero when input
// - Clock enable drives bus clock on pin
module spio_top #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic clk_en_in,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] adc_select_in,
    input wire logic [7:0] port_a_pin_in,
    output logic [7:0] port_a_pin_out,
    output logic [7:0] port_a_pin_oe_out,
    input wire logic [7:0] port_b_pin_in,
    output logic [7:0] port_b_pin_out,
    output logic [7:0] port_b_pin_oe_out,
    input wire logic [4:0] port_c_pin_in,
    output logic [4:0] port_c_pin_out,
    output logic [4:0] port_c_pin_oe_out,
    input wire logic [6:0] port_d_pin_in,
    output logic [6:0] port_d_pin_out,
    output logic [6:0] port_d_pin_oe_out,
    input wire logic [7:0] port_e_pin_in,
    output logic [7:0] port_e_pin_out,
    output logic [7:0] port_e_pin_oe_out,
    input wire logic [3:0] port_f_pin_in,
    output logic [3:0] port_f_pin_out,
    output logic [3:0] port_f_pin_oe_out
);

    // Bus slave state
    logic aw_hold_q;
    logic [3:0] aw_idx_q;
    logic aw_map_q;
    logic w_hold_q;
    logic [7:0] w_data_q;
    logic w_lane_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    // Port state, one entry per port
    logic [7:0] latch_q [spio_pkg::NUM_PORTS];
    logic [7:0] dir_q [spio_pkg::NUM_PORTS];
    logic [7:0] pin_w [spio_pkg::NUM_PORTS];
    logic [7:0] out_w [spio_pkg::NUM_PORTS];
    logic [7:0] oe_w [spio_pkg::NUM_PORTS];
    logic [7:0] rd_chain [spio_pkg::NUM_PORTS + 1];

    // Address decode
    wire [3:0] aw_idx = s_axi_awaddr[5:2];
    wire [3:0] ar_idx = s_axi_araddr[5:2];
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    wire ar_fire = s_axi_arvalid && s_axi_arready;
    wire aw_upper_zero = (s_axi_awaddr[ADDR_W-1:6] == '0) && (s_axi_awaddr[1:0] == 2'h0);
    wire ar_upper_zero = (s_axi_araddr[ADDR_W-1:6] == '0) && (s_axi_araddr[1:0] == 2'h0);
    wire aw_map = aw_upper_zero && (aw_idx <= spio_pkg::IDX_LAST)
        && (aw_idx != spio_pkg::IDX_GAP_LO) && (aw_idx != spio_pkg::IDX_GAP_HI);
    wire ar_map = ar_upper_zero && (ar_idx <= spio_pkg::IDX_LAST)
        && (ar_idx != spio_pkg::IDX_GAP_LO) && (ar_idx != spio_pkg::IDX_GAP_HI);
    wire do_write = clk_en_in && aw_hold_q && w_hold_q && !bvalid_q;
    wire wr_en = do_write && aw_map_q && w_lane_q;

    // Handshake outputs
    assign s_axi_awready = clk_en_in && !aw_hold_q;
    assign s_axi_wready = clk_en_in && !w_hold_q;
    assign s_axi_arready = clk_en_in && !rvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // Write address and data are caught independently
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            aw_hold_q <= 1'b0;
            aw_idx_q <= 4'h0;
            aw_map_q <= 1'b0;
        end else if (aw_fire) begin
            aw_hold_q <= 1'b1;
            aw_idx_q <= aw_idx;
            aw_map_q <= aw_map;
        end else if (do_write) begin
            aw_hold_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            w_hold_q <= 1'b0;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
        end else if (w_fire) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_hold_q <= 1'b0;
        end
    end

    // Write response
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            bvalid_q <= 1'b0;
            bresp_q <= spio_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= aw_map_q ? spio_pkg::RESP_OKAY : spio_pkg::RESP_SLVERR;
        end else if (clk_en_in && s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read answer
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            rvalid_q <= 1'b0;
            rresp_q <= spio_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rresp_q <= ar_map ? spio_pkg::RESP_OKAY : spio_pkg::RESP_SLVERR;
            rdata_q <= {24'h00_0000, rd_chain[spio_pkg::NUM_PORTS]};
        end else if (clk_en_in && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    // Pin inputs gathered to eight bits per port
    assign pin_w[0] = port_a_pin_in;
    assign pin_w[1] = port_b_pin_in;
    assign pin_w[2] = {3'h0, port_c_pin_in};
    assign pin_w[3] = {1'h0, port_d_pin_in};
    assign pin_w[4] = port_e_pin_in;
    assign pin_w[5] = {4'h0, port_f_pin_in};

    assign rd_chain[0] = 8'h00;

    // One latch and direction per port
    for (genvar p = 0; p < spio_pkg::NUM_PORTS; p++) begin : g_port
        wire wr_latch = wr_en && (aw_idx_q == spio_pkg::LATCH_IDX[p]);
        wire wr_dir = wr_en && (aw_idx_q == spio_pkg::DIR_IDX[p]);
        wire rd_latch = ar_map && (ar_idx == spio_pkg::LATCH_IDX[p]);
        wire rd_dir = ar_map && (ar_idx == spio_pkg::DIR_IDX[p]);
        wire [7:0] pmask = spio_pkg::PIN_MASK[p];
        wire [7:0] dir_pins = dir_q[p] & pmask;
        wire [7:0] adc_hide = (p == spio_pkg::PORT_B) ? adc_select_in : 8'h00;
        // Latch when output, pin when input
        wire [7:0] in_view = pin_w[p] & ~adc_hide;
        wire [7:0] data_view = ((latch_q[p] & dir_pins) | (in_view & ~dir_pins)) & pmask;
        wire [7:0] dir_view = dir_q[p] & spio_pkg::DIR_MASK[p];

        // Latches are not touched by reset
        always_ff @(posedge clk_in) begin
            if (wr_latch) begin
                latch_q[p] <= w_data_q & spio_pkg::LATCH_MASK[p];
            end
        end

        always_ff @(posedge clk_in) begin
            if (reset_in) begin
                dir_q[p] <= spio_pkg::DIR_RESET;
            end else if (wr_dir) begin
                dir_q[p] <= w_data_q & spio_pkg::DIR_MASK[p];
            end
        end

        // ADC pins read zero as inputs
        assign rd_chain[p + 1] = rd_chain[p]
            | (rd_latch ? data_view : 8'h00) | (rd_dir ? dir_view : 8'h00);
        assign out_w[p] = latch_q[p] & dir_pins;
        assign oe_w[p] = dir_pins & ~adc_hide;
    end

    assign port_a_pin_out = out_w[0];
    assign port_a_pin_oe_out = oe_w[0];
    assign port_b_pin_out = out_w[1];
    assign port_b_pin_oe_out = oe_w[1];
    assign port_d_pin_out = out_w[3][6:0];
    assign port_d_pin_oe_out = oe_w[3][6:0];
    assign port_e_pin_out = out_w[4];
    assign port_e_pin_oe_out = oe_w[4];
    assign port_f_pin_out = out_w[5][3:0];
    assign port_f_pin_oe_out = oe_w[5][3:0];

    // Bus clock replaces latch on pin two
    wire bus_clock_out_enable = dir_q[spio_pkg::PORT_C][spio_pkg::MCLK_EN_BIT];
    assign port_c_pin_out = bus_clock_out_enable
        ? {out_w[2][4:3], clk_in, out_w[2][1:0]} : out_w[2][4:0];
    assign port_c_pin_oe_out = bus_clock_out_enable
        ? {oe_w[2][4:3], 1'b1, oe_w[2][1:0]} : oe_w[2][4:0];

    // Assertions
    property p_reset_inputs;
        @(posedge clk_in) disable iff (reset_in)
        $fell(reset_in) |-> (port_a_pin_oe_out == 8'h00) && (port_b_pin_oe_out == 8'h00)
            && (port_c_pin_oe_out == 5'h00) && (port_f_pin_oe_out == 4'h0);
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs after reset");

    property p_dir_a_oe;
        @(posedge clk_in) disable iff (reset_in)
        (wr_en && aw_idx_q == spio_pkg::IDX_A_DIR) |=> port_a_pin_oe_out == $past(w_data_q);
    endproperty
    a_dir_a_oe: assert property (p_dir_a_oe) else $error("port A enable not from write");

    property p_read_a;
        @(posedge clk_in) disable iff (reset_in)
        (ar_fire && ar_map && ar_idx == spio_pkg::IDX_A_LATCH) |=> s_axi_rvalid
            && s_axi_rdata[7:0] == $past((latch_q[0] & dir_q[0]) | (port_a_pin_in & ~dir_q[0]));
    endproperty
    a_read_a: assert property (p_read_a) else $error("port A read mixes wrong");

    property p_adc_zero;
        @(posedge clk_in) disable iff (reset_in)
        (ar_fire && ar_idx == spio_pkg::IDX_B_LATCH)
            |=> (s_axi_rdata[7:0] & $past(adc_select_in & ~dir_q[1])) == 8'h00;
    endproperty
    a_adc_zero: assert property (p_adc_zero) else $error("ADC pin read not zero");

    property p_mclk_drive;
        @(posedge clk_in) disable iff (reset_in)
        (wr_en && aw_idx_q == spio_pkg::IDX_C_DIR && w_data_q[7])
            |=> port_c_pin_oe_out[2];
    endproperty
    a_mclk_drive: assert property (p_mclk_drive) else $error("clock pin not driven");

    property p_c_reserved;
        @(posedge clk_in) disable iff (reset_in)
        (ar_fire && (ar_idx == spio_pkg::IDX_C_LATCH || ar_idx == spio_pkg::IDX_C_DIR))
            |=> s_axi_rdata[31:8] == 24'h00_0000 && s_axi_rdata[6:5] == 2'h0;
    endproperty
    a_c_reserved: assert property (p_c_reserved) else $error("port C reserved bits set");

    property p_df_reserved;
        @(posedge clk_in) disable iff (reset_in)
        (ar_fire && (ar_idx == spio_pkg::IDX_D_DIR || ar_idx == spio_pkg::IDX_F_DIR))
            |=> s_axi_rdata[7] == 1'b0 ##0 (!$past(ar_idx == spio_pkg::IDX_F_DIR)
            || s_axi_rdata[7:4] == 4'h0);
    endproperty
    a_df_reserved: assert property (p_df_reserved) else $error("direction reserved bit set");

    property p_gap;
        @(posedge clk_in) disable iff (reset_in)
        (ar_fire && (ar_idx == spio_pkg::IDX_GAP_LO || ar_idx == spio_pkg::IDX_GAP_HI))
            |=> s_axi_rresp == spio_pkg::RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
    endproperty
    a_gap: assert property (p_gap) else $error("gap address answered as register");

    property p_bvalid_hold;
        @(posedge clk_in) disable iff (reset_in)
        (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bvalid_hold: assert property (p_bvalid_hold) else $error("write answer dropped");

    property p_latch_kept;
        @(posedge clk_in)
        (reset_in && !wr_en) |=> $stable(latch_q[4]);
    endproperty
    a_latch_kept: assert property (p_latch_kept) else $error("latch changed by reset");

    property p_freeze;
        @(posedge clk_in) disable iff (reset_in)
        !clk_en_in |=> $stable(s_axi_bvalid) && $stable(s_axi_rvalid) && $stable(dir_q[0]);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved with enable low");

    property p_dir_f_oe;
        @(posedge clk_in) disable iff (reset_in)
        (wr_en && aw_idx_q == spio_pkg::IDX_F_DIR)
            |=> port_f_pin_oe_out == $past(w_data_q[3:0]);
    endproperty
    a_dir_f_oe: assert property (p_dir_f_oe) else $error("port F enable not from write");

    property p_latch_e;
        @(posedge clk_in) disable iff (reset_in)
        (wr_en && aw_idx_q == spio_pkg::IDX_E_LATCH) |=> latch_q[4] == $past(w_data_q);
    endproperty
    a_latch_e: assert property (p_latch_e) else $error("port E latch not written");

    property p_c_latch_mask;
        @(posedge clk_in) disable iff (reset_in)
        (wr_en && aw_idx_q == spio_pkg::IDX_C_LATCH) |=> latch_q[2][7:5] == 3'h0;
    endproperty
    a_c_latch_mask: assert property (p_c_latch_mask) else $error("port C upper bits kept");

    property p_read_b_dir;
        @(posedge clk_in) disable iff (reset_in)
        (ar_fire && ar_map && ar_idx == spio_pkg::IDX_B_DIR) |=> s_axi_rdata[7:0] == $past(dir_q[1]);
    endproperty
    a_read_b_dir: assert property (p_read_b_dir) else $error("port B direction read wrong");

    property p_reset_de;
        @(posedge clk_in) disable iff (reset_in)
        $fell(reset_in) |-> (port_d_pin_oe_out == 7'h00) && (port_e_pin_oe_out == 8'h00);
    endproperty
    a_reset_de: assert property (p_reset_de) else $error("port D or E driven after reset");

endmodule : spio_top

// File: tb/spio_pin_board.sv
`timescale 1ns/1ps
module spio_pin_board #(
    parameter int W = 8
) (
    input wire logic [W-1:0] drive_in,
    input wire logic [W-1:0] oe_in,
    input wire logic [W-1:0] board_in,
    output logic [W-1:0] level_out
);
    // Driven pins show the device, released pins the board level
    assign level_out = (oe_in & drive_in) | (~oe_in & board_in);
endmodule : spio_pin_board

// File: tb/test_six_port_parallel_io.sv
`timescale 1ns/1ps
module test_six_port_parallel_io;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, adc_select_in = 8'h00;
    logic [31:0] s_axi_wdata = 32'h00000000;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [31:0] s_axi_rdata;
    logic [5:0][7:0] board_q = {6{8'h00}};
    logic [7:0] port_a_pin_in, port_a_pin_out, port_a_pin_oe_out;
    logic [7:0] port_b_pin_in, port_b_pin_out, port_b_pin_oe_out;
    logic [4:0] port_c_pin_in, port_c_pin_out, port_c_pin_oe_out;
    logic [6:0] port_d_pin_in, port_d_pin_out, port_d_pin_oe_out;
    logic [7:0] port_e_pin_in, port_e_pin_out, port_e_pin_oe_out;
    logic [3:0] port_f_pin_in, port_f_pin_out, port_f_pin_oe_out;
    logic [5:0][7:0] out_all, oe_all;
    int n_errors = 0;
    int n_compared = 0;

    always #10 clk_in = ~clk_in;

    assign out_all = {4'h0, port_f_pin_out, port_e_pin_out, 1'b0, port_d_pin_out,
        3'h0, port_c_pin_out, port_b_pin_out, port_a_pin_out};
    assign oe_all = {4'h0, port_f_pin_oe_out, port_e_pin_oe_out, 1'b0, port_d_pin_oe_out,
        3'h0, port_c_pin_oe_out, port_b_pin_oe_out, port_a_pin_oe_out};

    spio_top DUT (.clk_in, .reset_in, .clk_en_in,
        .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .adc_select_in,
        .port_a_pin_in, .port_a_pin_out, .port_a_pin_oe_out,
        .port_b_pin_in, .port_b_pin_out, .port_b_pin_oe_out,
        .port_c_pin_in, .port_c_pin_out, .port_c_pin_oe_out,
        .port_d_pin_in, .port_d_pin_out, .port_d_pin_oe_out,
        .port_e_pin_in, .port_e_pin_out, .port_e_pin_oe_out,
        .port_f_pin_in, .port_f_pin_out, .port_f_pin_oe_out);

    spio_pin_board u_pa (.drive_in(port_a_pin_out), .oe_in(port_a_pin_oe_out),
        .board_in(board_q[0]), .level_out(port_a_pin_in));
    spio_pin_board u_pb (.drive_in(port_b_pin_out), .oe_in(port_b_pin_oe_out),
        .board_in(board_q[1]), .level_out(port_b_pin_in));
    spio_pin_board #(.W(5)) u_pc (.drive_in(port_c_pin_out), .oe_in(port_c_pin_oe_out),
        .board_in(board_q[2][4:0]), .level_out(port_c_pin_in));
    spio_pin_board #(.W(7)) u_pd (.drive_in(port_d_pin_out), .oe_in(port_d_pin_oe_out),
        .board_in(board_q[3][6:0]), .level_out(port_d_pin_in));
    spio_pin_board u_pe (.drive_in(port_e_pin_out), .oe_in(port_e_pin_oe_out),
        .board_in(board_q[4]), .level_out(port_e_pin_in));
    spio_pin_board #(.W(4)) u_pf (.drive_in(port_f_pin_out), .oe_in(port_f_pin_oe_out),
        .board_in(board_q[5][3:0]), .level_out(port_f_pin_in));

    task automatic give_verdict();
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
            n_errors++;
        end
    endtask : check

    function automatic logic [7:0] addr_of(input logic [3:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction : addr_of

    task automatic axi_write(input logic [7:0] addr, input logic [7:0] data,
        input logic [3:0] strb, output logic [1:0] rsp);
        logic aw_ok, w_ok, b_ok;
        b_ok = 1'b0;
        rsp = 2'h3;
        @(posedge clk_in);
        s_axi_awaddr <= addr;
        s_axi_wdata <= {24'h000000, data};
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 50 && !b_ok; n++) begin
            @(negedge clk_in);
            aw_ok = s_axi_awvalid & s_axi_awready;
            w_ok = s_axi_wvalid & s_axi_wready;
            b_ok = s_axi_bvalid & s_axi_bready;
            rsp = s_axi_bresp;
            @(posedge clk_in);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
            if (b_ok) s_axi_bready <= 1'b0;
        end
        if (!b_ok) begin
            n_errors++;
            give_verdict();
        end
    endtask : axi_write

    task automatic axi_read(input logic [7:0] addr, output logic [31:0] data,
        output logic [1:0] rsp);
        logic ar_ok, r_ok;
        r_ok = 1'b0;
        @(posedge clk_in);
        s_axi_araddr <= addr;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 50 && !r_ok; n++) begin
            @(negedge clk_in);
            ar_ok = s_axi_arvalid & s_axi_arready;
            r_ok = s_axi_rvalid & s_axi_rready;
            data = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge clk_in);
            if (ar_ok) s_axi_arvalid <= 1'b0;
            if (r_ok) s_axi_rready <= 1'b0;
        end
        if (!r_ok) begin
            n_errors++;
            give_verdict();
        end
    endtask : axi_read

    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        axi_write(addr, data, 4'hF, resp);
        check(32'(resp), 32'(spio_pkg::RESP_OKAY));
    endtask : wr

    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        logic [31:0] data;
        axi_read(addr, data, resp);
        check(32'(resp), 32'(spio_pkg::RESP_OKAY));
        check(data, 32'(exp));
    endtask : rd_chk

    task automatic sc_masks();
        for (int p = 0; p < spio_pkg::NUM_PORTS; p++) begin
            wr(addr_of(spio_pkg::LATCH_IDX[p]), 8'hFF);
            wr(addr_of(spio_pkg::DIR_IDX[p]), 8'hFF);
            rd_chk(addr_of(spio_pkg::LATCH_IDX[p]), spio_pkg::LATCH_MASK[p]);
            rd_chk(addr_of(spio_pkg::DIR_IDX[p]), spio_pkg::DIR_MASK[p]);
            check(32'(oe_all[p]), 32'(spio_pkg::PIN_MASK[p]));
        end
    endtask : sc_masks

    task automatic sc_reset_keep();
        @(posedge clk_in);
        reset_in <= 1'b1;
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        for (int p = 0; p < spio_pkg::NUM_PORTS; p++) begin
            rd_chk(addr_of(spio_pkg::DIR_IDX[p]), spio_pkg::DIR_RESET);
            check(32'(oe_all[p]), 32'h00000000);
            wr(addr_of(spio_pkg::DIR_IDX[p]), 8'hFF);
            rd_chk(addr_of(spio_pkg::LATCH_IDX[p]), spio_pkg::LATCH_MASK[p]);
        end
    endtask : sc_reset_keep

    task automatic sc_unmapped();
        logic [31:0] data;
        axi_write(8'h28, 8'h5A, 4'hF, resp);
        check(32'(resp), 32'(spio_pkg::RESP_SLVERR));
        axi_read(8'h2C, data, resp);
        check(32'(resp), 32'(spio_pkg::RESP_SLVERR));
        check(data, 32'h00000000);
        axi_read(8'h01, data, resp);
        check(32'(resp), 32'(spio_pkg::RESP_SLVERR));
        wr(addr_of(spio_pkg::IDX_A_LATCH), 8'h3C);
        axi_write(addr_of(spio_pkg::IDX_A_LATCH), 8'hC3, 4'h0, resp);
        check(32'(resp), 32'(spio_pkg::RESP_OKAY));
        rd_chk(addr_of(spio_pkg::IDX_A_LATCH), 8'h3C);
    endtask : sc_unmapped

    task automatic sc_read_mix();
        board_q <= {6{8'hC9}};
        for (int p = 0; p < spio_pkg::NUM_PORTS; p++) begin
            wr(addr_of(spio_pkg::LATCH_IDX[p]), 8'h35);
            wr(addr_of(spio_pkg::DIR_IDX[p]), 8'h0F);
            rd_chk(addr_of(spio_pkg::LATCH_IDX[p]), 8'hC5 & spio_pkg::LATCH_MASK[p]);
            check(32'(oe_all[p]), 32'(8'h0F & spio_pkg::PIN_MASK[p]));
            check(32'(out_all[p]), 32'(8'h05 & spio_pkg::PIN_MASK[p]));
        end
    endtask : sc_read_mix

    task automatic sc_adc();
        adc_select_in <= 8'hF0;
        board_q[1] <= 8'h55;
        wr(addr_of(spio_pkg::IDX_B_LATCH), 8'hAA);
        wr(addr_of(spio_pkg::IDX_B_DIR), 8'hCC);
        rd_chk(addr_of(spio_pkg::IDX_B_LATCH), 8'h89);
        check(32'(port_b_pin_oe_out), 32'h0000000C);
    endtask : sc_adc

    task automatic sc_bus_clock();
        wr(addr_of(spio_pkg::IDX_C_DIR), 8'h80);
        rd_chk(addr_of(spio_pkg::IDX_C_DIR), 8'h80);
        check(32'(port_c_pin_oe_out), 32'h00000004);
        @(posedge clk_in);
        #1;
        check(32'(port_c_pin_out[2]), 32'h00000001);
        @(negedge clk_in);
        #1;
        check(32'(port_c_pin_out[2]), 32'h00000000);
        wr(addr_of(spio_pkg::IDX_C_DIR), 8'h00);
        check(32'(port_c_pin_oe_out), 32'h00000000);
    endtask : sc_bus_clock

    task automatic sc_clk_en();
        @(posedge clk_in);
        clk_en_in <= 1'b0;
        s_axi_awprot <= 3'h7;
        s_axi_arprot <= 3'h7;
        fork
            wr(addr_of(spio_pkg::IDX_E_DIR), 8'hA5);
            begin
                repeat (4) @(negedge clk_in);
                check(32'({s_axi_awready, s_axi_wready, s_axi_arready}), 32'h0);
                check(32'(port_e_pin_oe_out), 32'h0000000F);
                @(posedge clk_in);
                clk_en_in <= 1'b1;
            end
        join
        check(32'(port_e_pin_oe_out), 32'h000000A5);
        rd_chk(addr_of(spio_pkg::IDX_E_DIR), 8'hA5);
    endtask : sc_clk_en

    initial begin
        repeat (5) @(posedge clk_in);
        reset_in <= 1'b0;
        #1;
        check(32'(oe_all[3:0]), 32'h00000000);
        sc_masks();
        sc_reset_keep();
        sc_unmapped();
        sc_read_mix();
        sc_adc();
        sc_bus_clock();
        sc_clk_en();
        give_verdict();
    end
endmodule : test_six_port_parallel_io
